// *** rtl/radio_service_consts.vh ***
/*
  Constants of the radio service and status register group: register
  indices, field positions, reset values, operating mode codes and the
  temperature step table.
  Assumes it is included by bare name from the register bank module.
*/
`ifndef RADIO_SERVICE_CONSTS_VH
`define RADIO_SERVICE_CONSTS_VH

// ==========================================================
// Register indices; the byte address is four times the index.
`define IDX_IMAGE_CAL      8'h3B
`define IDX_TEMP_READING   8'h3C
`define IDX_LOW_BATTERY    8'h3D
`define IDX_EVENT_FLAGS    8'h3E
`define IDX_IRQ_STATUS     8'h50
`define IDX_IRQ_MASK       8'h51

// ==========================================================
// Field positions.
`define BIT_AUTO_RECAL     7
`define BIT_RECAL_TRIGGER  6
`define BIT_RECAL_BUSY     5
`define BIT_TEMP_SHIFT     3
`define MSB_TEMP_LIMIT     2
`define LSB_TEMP_LIMIT     1
`define BIT_MONITOR_OFF    0
`define BIT_SUPPLY_ENABLE  3
`define MSB_SUPPLY_SELECT  2
`define BIT_MODE_REACHED   7
`define BIT_RX_READY       6
`define BIT_TX_READY       5
`define BIT_SYNTH_LOCKED   4
`define BIT_STRENGTH       3
`define BIT_TIMEOUT        2
`define BIT_PREAMBLE       1
`define BIT_SYNC_MATCH     0

// ==========================================================
// Reset values.
`define RST_TEMP_LIMIT     2'h1
`define RST_SUPPLY_SELECT  3'h2
`define RST_BYTE           8'h00

// ==========================================================
// Operating mode codes on op_mode_i.
`define MODE_SLEEP         3'h0
`define MODE_STANDBY       3'h1
`define MODE_SYNTH         3'h2
`define MODE_TX            3'h3
`define MODE_RX            3'h5

// ==========================================================
// Temperature steps in degrees, one per limit code.
`define TEMP_STEP_0        9'h005
`define TEMP_STEP_1        9'h00A
`define TEMP_STEP_2        9'h00F
`define TEMP_STEP_3        9'h014

`endif

// *** rtl/radio_service_status_regs.v ***
/*
  Service and status register bank of a sub-GHz radio: calibration
  control, temperature monitor, low-supply detector control, the
  primary event flag register and an interrupt status and mask pair,
  all reached over an Avalon-MM slave with waitrequest.
  Assumes the radio core runs on clk_sys_i, so its event inputs need
  no synchronisers, and that it runs the calibration itself after a
  recal_start_o pulse and answers with recal_done_i.
*/
// Notes on behaviour
// - Auto recalibration bit enables temperature-driven receiver recalibration when one.
// - Writing one to trigger in standby starts calibration; trigger stores nothing.
// - Busy bit reads one while calibration runs; resets to zero.
// - Temperature shift flag reads one when drift since calibration exceeds limit.
// - Limit code selects 5, 10, 15 or 20 degrees; resets to 01.
// - Monitor disable stops monitoring; else monitoring outside sleep and standby.
// - Temperature reading is eight bits, minus one degree per step.
// - Supply detector enable bit, reset zero; upper bits unused, read zero.
// - Supply threshold select picks one of eight ascending levels; resets 010.
// - Mode reached flag sets when requested mode is ready; clears on change.
// - Receive ready sets after receiver settling; clears leaving receive.
// - Transmit ready sets after amplifier ramp; clears leaving transmit.
// - Synth locked flag shows lock in synthesis, receive and transmit.
// - Strength flag sets above limit in receive; clears leaving or write one.
// - Timeout flag sets on timeout; clears leaving receive or FIFO emptied.
// - Preamble flag sets on valid preamble; clears only by write one.
// - Sync flag sets on sync match; clears leaving receive or FIFO emptied.
// - Sync flag is write-one-clear only in continuous mode.
`timescale 1ns/1ps
`include "radio_service_consts.vh"

module radio_service_status_regs (
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  input  wire [9:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  output wire        irq_o,
  input  wire [2:0]  op_mode_i,
  input  wire        osc_running_i,
  input  wire        pll_locked_i,
  input  wire        rssi_sampling_start_i,
  input  wire        rx_settled_i,
  input  wire        pa_ramp_done_i,
  input  wire [7:0]  signal_strength_reading_i,
  input  wire [7:0]  signal_strength_limit_i,
  input  wire        timeout_event_i,
  input  wire        fifo_empty_i,
  input  wire        preamble_event_i,
  input  wire        sync_event_i,
  input  wire        continuous_mode_i,
  input  wire [7:0]  temp_sample_i,
  input  wire        temp_sample_valid_i,
  input  wire        recal_done_i,
  output reg         recal_start_o,
  output wire        auto_recal_enable_o,
  output wire        thermal_monitor_active_o,
  output wire        supply_detector_enable_o,
  output wire [2:0]  supply_threshold_select_o
);

  // ==========================================================
  // Bus slave

  reg        ack;
  wire [7:0] idx;
  wire       wr_go;
  wire       wr_lane;

  // Each access waits exactly one cycle so read data can be registered.
  // The cost is one wait cycle per access, even for back-to-back requests.
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign idx     = avs_address_i[9:2];
  assign wr_lane = avs_byteenable_i[0];
  assign wr_go   = avs_write_i & ack & wr_lane;

  // The ack flop rises in the waiting cycle and drops after the accept edge.
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
    end
  end

  // ==========================================================
  // Control registers

  reg       auto_recal_enable;
  reg [1:0] temp_shift_limit;
  reg       thermal_monitor_disable;
  reg       supply_detector_enable;
  reg [2:0] supply_threshold_select;
  reg [7:0] irq_mask;

  wire wr_cal  = wr_go & (idx == `IDX_IMAGE_CAL);
  wire wr_bat  = wr_go & (idx == `IDX_LOW_BATTERY);
  wire wr_flg  = wr_go & (idx == `IDX_EVENT_FLAGS);
  wire wr_ist  = wr_go & (idx == `IDX_IRQ_STATUS);
  wire wr_imsk = wr_go & (idx == `IDX_IRQ_MASK);

  // Software-owned settings.
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      auto_recal_enable       <= 1'b0;
      temp_shift_limit        <= `RST_TEMP_LIMIT;
      thermal_monitor_disable <= 1'b0;
      supply_detector_enable  <= 1'b0;
      supply_threshold_select <= `RST_SUPPLY_SELECT;
      irq_mask                <= `RST_BYTE;
    end else begin
      if (wr_cal) begin
        auto_recal_enable       <= avs_writedata_i[`BIT_AUTO_RECAL];
        temp_shift_limit        <= avs_writedata_i[`MSB_TEMP_LIMIT:`LSB_TEMP_LIMIT];
        thermal_monitor_disable <= avs_writedata_i[`BIT_MONITOR_OFF];
      end
      if (wr_bat) begin
        supply_detector_enable  <= avs_writedata_i[`BIT_SUPPLY_ENABLE];
        supply_threshold_select <= avs_writedata_i[`MSB_SUPPLY_SELECT:0];
      end
      if (wr_imsk) begin
        irq_mask <= avs_writedata_i[7:0];
      end
    end
  end

  assign auto_recal_enable_o       = auto_recal_enable;
  assign supply_detector_enable_o  = supply_detector_enable;
  assign supply_threshold_select_o = supply_threshold_select;

  // ==========================================================
  // Mode tracking

  reg  [2:0] mode_q;
  reg        fifo_empty_q;
  wire       in_rx    = (op_mode_i == `MODE_RX);
  wire       in_tx    = (op_mode_i == `MODE_TX);
  wire       in_synth = (op_mode_i == `MODE_SYNTH);
  wire       in_stby  = (op_mode_i == `MODE_STANDBY);
  wire       in_sleep = (op_mode_i == `MODE_SLEEP);
  wire       mode_chg = (op_mode_i != mode_q);
  wire       left_rx  = (mode_q == `MODE_RX) & ~in_rx;
  wire       emptied  = fifo_empty_i & ~fifo_empty_q;

  // Previous mode and FIFO state give the change and emptied events.
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      mode_q       <= `MODE_SLEEP;
      fifo_empty_q <= 1'b1;
    end else begin
      mode_q       <= op_mode_i;
      fifo_empty_q <= fifo_empty_i;
    end
  end

  // ==========================================================
  // Temperature monitor and calibration

  reg  [7:0] thermal_reading;
  reg  [7:0] temp_reference;
  reg        recal_busy;
  reg  [8:0] step;
  wire [8:0] drift;
  wire       temp_shift_flag;
  wire       manual_go;
  wire       auto_go;

  // Monitoring is off in sleep and standby and when disabled.
  assign thermal_monitor_active_o = ~thermal_monitor_disable & ~in_sleep & ~in_stby;

  // Step table for the shift limit.
  always @* begin
    case (temp_shift_limit)
      2'h0:    step = `TEMP_STEP_0;
      2'h1:    step = `TEMP_STEP_1;
      2'h2:    step = `TEMP_STEP_2;
      default: step = `TEMP_STEP_3;
    endcase
  end

  // Absolute drift from the reading kept at the last calibration.
  // Warming and cooling count alike, since only the magnitude is compared.
  assign drift = (thermal_reading >= temp_reference) ?
                 ({1'b0, thermal_reading} - {1'b0, temp_reference}) :
                 ({1'b0, temp_reference} - {1'b0, thermal_reading});
  assign temp_shift_flag = (drift > step);

  // A trigger outside standby, or while busy, is dropped.
  assign manual_go = wr_cal & avs_writedata_i[`BIT_RECAL_TRIGGER] & in_stby & ~recal_busy;
  // Busy masks the still-high shift flag so one drift starts one run.
  assign auto_go   = auto_recal_enable & temp_shift_flag & ~recal_busy;

  // Reading, reference, busy and the start pulse.
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      thermal_reading <= `RST_BYTE;
      temp_reference  <= `RST_BYTE;
      recal_busy      <= 1'b0;
      recal_start_o   <= 1'b0;
    end else begin
      if (thermal_monitor_active_o & temp_sample_valid_i) begin
        thermal_reading <= temp_sample_i;
      end
      recal_start_o <= manual_go | auto_go;
      if (manual_go | auto_go) begin
        recal_busy <= 1'b1;
      end else if (recal_done_i) begin
        recal_busy     <= 1'b0;
        temp_reference <= thermal_reading;
      end
    end
  end

  // ==========================================================
  // Primary event flags

  reg  mode_reached_flag;
  reg  receive_ready_flag;
  reg  transmit_ready_flag;
  reg  strength_flag;
  reg  timeout_flag;
  reg  preamble_found_flag;
  reg  sync_match_flag;
  wire synth_locked_flag;
  wire mode_ready_set;
  wire strength_set;

  assign mode_ready_set = in_sleep |
                          (in_stby & osc_running_i) |
                          (in_synth & pll_locked_i) |
                          (in_rx & rssi_sampling_start_i) |
                          (in_tx & pa_ramp_done_i);
  assign strength_set = in_rx & (signal_strength_reading_i > signal_strength_limit_i);
  assign synth_locked_flag = pll_locked_i & (in_synth | in_rx | in_tx);

  // Sets always win over any clear in the same cycle.
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      mode_reached_flag   <= 1'b0;
      receive_ready_flag  <= 1'b0;
      transmit_ready_flag <= 1'b0;
      strength_flag       <= 1'b0;
      timeout_flag        <= 1'b0;
      preamble_found_flag <= 1'b0;
      sync_match_flag     <= 1'b0;
    end else begin
      if (mode_ready_set) begin
        mode_reached_flag <= 1'b1;
      end else if (mode_chg) begin
        mode_reached_flag <= 1'b0;
      end
      if (in_rx & rx_settled_i) begin
        receive_ready_flag <= 1'b1;
      end else if (~in_rx) begin
        receive_ready_flag <= 1'b0;
      end
      if (in_tx & pa_ramp_done_i) begin
        transmit_ready_flag <= 1'b1;
      end else if (~in_tx) begin
        transmit_ready_flag <= 1'b0;
      end
      if (strength_set) begin
        strength_flag <= 1'b1;
      end else if (left_rx | (wr_flg & avs_writedata_i[`BIT_STRENGTH])) begin
        strength_flag <= 1'b0;
      end
      if (timeout_event_i) begin
        timeout_flag <= 1'b1;
      end else if (left_rx | emptied) begin
        timeout_flag <= 1'b0;
      end
      if (preamble_event_i) begin
        preamble_found_flag <= 1'b1;
      end else if (wr_flg & avs_writedata_i[`BIT_PREAMBLE]) begin
        preamble_found_flag <= 1'b0;
      end
      if (sync_event_i) begin
        sync_match_flag <= 1'b1;
      end else if (left_rx | emptied |
                   (continuous_mode_i & wr_flg & avs_writedata_i[`BIT_SYNC_MATCH])) begin
        sync_match_flag <= 1'b0;
      end
    end
  end

  reg [7:0] flags;

  // Flags register layout; the lock flag is live, every other bit is held.
  always @* begin
    flags                    = `RST_BYTE;
    flags[`BIT_MODE_REACHED] = mode_reached_flag;
    flags[`BIT_RX_READY]     = receive_ready_flag;
    flags[`BIT_TX_READY]     = transmit_ready_flag;
    flags[`BIT_SYNTH_LOCKED] = synth_locked_flag;
    flags[`BIT_STRENGTH]     = strength_flag;
    flags[`BIT_TIMEOUT]      = timeout_flag;
    flags[`BIT_PREAMBLE]     = preamble_found_flag;
    flags[`BIT_SYNC_MATCH]   = sync_match_flag;
  end

  // ==========================================================
  // Interrupt status and mask

  reg  [7:0] flags_q;
  reg  [7:0] irq_status;
  wire [7:0] rises = flags & ~flags_q;
  wire [7:0] w1c   = wr_ist ? avs_writedata_i[7:0] : 8'h00;

  // Each rising flag latches a sticky bit; a rise beats a clear.
  // A flag that stays high latches once; a new event needs the flag to fall first.
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      flags_q    <= `RST_BYTE;
      irq_status <= `RST_BYTE;
    end else begin
      flags_q    <= flags;
      irq_status <= rises | (irq_status & ~w1c);
    end
  end

  assign irq_o = |(irq_status & irq_mask);

  // ==========================================================
  // Read data

  reg [7:0] rd_byte;
  reg [7:0] cal_byte;
  reg [7:0] bat_byte;

  // Calibration byte; the trigger bit and bit 4 are never stored, so they read zero.
  always @* begin
    cal_byte                                  = `RST_BYTE;
    cal_byte[`BIT_AUTO_RECAL]                 = auto_recal_enable;
    cal_byte[`BIT_RECAL_BUSY]                 = recal_busy;
    cal_byte[`BIT_TEMP_SHIFT]                 = temp_shift_flag;
    cal_byte[`MSB_TEMP_LIMIT:`LSB_TEMP_LIMIT] = temp_shift_limit;
    cal_byte[`BIT_MONITOR_OFF]                = thermal_monitor_disable;
  end

  // Low supply byte; bits 7 to 4 are unused and read zero.
  always @* begin
    bat_byte                       = `RST_BYTE;
    bat_byte[`BIT_SUPPLY_ENABLE]   = supply_detector_enable;
    bat_byte[`MSB_SUPPLY_SELECT:0] = supply_threshold_select;
  end

  // Unmapped indices read zero.
  always @* begin
    case (idx)
      `IDX_IMAGE_CAL:    rd_byte = cal_byte;
      `IDX_TEMP_READING: rd_byte = thermal_reading;
      `IDX_LOW_BATTERY:  rd_byte = bat_byte;
      `IDX_EVENT_FLAGS:  rd_byte = flags;
      `IDX_IRQ_STATUS:   rd_byte = irq_status;
      `IDX_IRQ_MASK:     rd_byte = irq_mask;
      default:           rd_byte = 8'h00;
    endcase
  end

  // Data is loaded in the waiting cycle and stands at the accept edge.
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i & ~ack) begin
      avs_readdata_o <= {24'h000000, rd_byte};
    end
  end

endmodule

// *** verification/radio_service_props.sv ***
/*
  Checker for the radio service and status register bank.
  Assumes it is bound to the bank's ports and that the constants
  header is on the include path.
*/
`timescale 1ns/1ps
`include "radio_service_consts.vh"
module radio_service_props (
  input wire        clk_sys_i,
  input wire        sys_rst_i,
  input wire [9:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        irq_o,
  input wire [2:0]  op_mode_i,
  input wire        recal_start_o,
  input wire        auto_recal_enable_o,
  input wire        thermal_monitor_active_o,
  input wire        supply_detector_enable_o,
  input wire [2:0]  supply_threshold_select_o
);
  // ====================
  // Clocking and helpers.
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  wire req = avs_read_i | avs_write_i;

  // A write to one register index, seen at the edge that completes it.
  sequence s_wr(idx);
    avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i[9:2] == idx;
  endsequence

  // A trigger write with auto recalibration off, so no other start can follow.
  sequence s_trig_off;
    s_wr(`IDX_IMAGE_CAL) ##0 (avs_writedata_i[6] && !avs_writedata_i[7]
      && !auto_recal_enable_o && op_mode_i != `MODE_STANDBY);
  endsequence

  // ====================
  // Assertions.
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("no wait in first request cycle");
  a_wait_once: assert property (req && avs_waitrequest_o ##1 req |-> !avs_waitrequest_o)
    else $error("wait held too long");
  a_idle_wait: assert property (!req |-> !avs_waitrequest_o)
    else $error("wait without request");
  a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
    && !(avs_address_i[9:2] inside {[8'h3B:8'h3E], 8'h50, 8'h51}) |-> avs_readdata_o == 0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_start_pulse: assert property (recal_start_o |=> !recal_start_o)
    else $error("start pulse too long");
  a_trig_ignored: assert property (s_trig_off |=> !recal_start_o[*2])
    else $error("trigger taken outside standby");
  a_supply_write: assert property (s_wr(`IDX_LOW_BATTERY) |=>
    supply_detector_enable_o == $past(avs_writedata_i[3])
    && supply_threshold_select_o == $past(avs_writedata_i[2:0]))
    else $error("supply control not written");
  a_auto_write: assert property (s_wr(`IDX_IMAGE_CAL) |=>
    auto_recal_enable_o == $past(avs_writedata_i[7]))
    else $error("auto enable not written");
  a_monitor_idle: assert property (op_mode_i == `MODE_SLEEP
    || op_mode_i == `MODE_STANDBY |-> !thermal_monitor_active_o)
    else $error("monitor active when idle");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst_i |=> !irq_o
    && !recal_start_o && !supply_detector_enable_o && supply_threshold_select_o == 3'h2)
    else $error("bad value after reset");
endmodule

bind radio_service_status_regs radio_service_props radio_service_props_inst (.*);

// *** verification/tb_top.sv ***
/*
  Directed bench for the radio service and status register bank.
  Assumes the design, its header and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "radio_service_consts.vh"
module tb_top;
  reg         clk_sys_i, sys_rst_i, avs_read_i, avs_write_i;
  reg  [9:0]  avs_address_i;
  reg  [31:0] avs_writedata_i;
  reg  [2:0]  op_mode_i;
  reg  [7:0]  signal_strength_reading_i, temp_sample_i, q;
  reg         pll_locked_i, pa_ramp_done_i, timeout_event_i, fifo_empty_i;
  reg         preamble_event_i, sync_event_i, continuous_mode_i;
  reg         temp_sample_valid_i, recal_done_i;
  reg         osc_running_i, rx_settled_i, rssi_sampling_start_i;
  wire [31:0] avs_readdata_o;
  wire        avs_waitrequest_o, irq_o, recal_start_o, auto_recal_enable_o;
  wire        thermal_monitor_active_o, supply_detector_enable_o;
  wire [2:0]  supply_threshold_select_o;
  integer     mismatches, n_checks, i;
  integer     cyc = 0;

  // ====================
  // Tied inputs: whole-byte writes and a fixed strength limit.
  radio_service_status_regs radio_service_status_regs_inst (
    .avs_byteenable_i        (4'hF),
    .signal_strength_limit_i (8'h40),
    .*
  );

  // ====================
  // Clock and hang guard; a few hundred cycles are expected.
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      mismatches = mismatches + 1;
      results;
    end
  end

  // ====================
  // Shared tasks.
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // One bus cycle: held until waitrequest is sampled low at a rising edge, data taken
  // at that edge; ends at the falling edge after release so outputs have settled.
  task bus(input w, input [9:0] a, input [7:0] d);
    begin
      @(posedge clk_sys_i);
      avs_read_i <= !w;
      avs_write_i <= w;
      avs_address_i <= a;
      avs_writedata_i <= {24'h0, d};
      @(posedge clk_sys_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
      q = avs_readdata_o[7:0];
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      @(negedge clk_sys_i);
    end
  endtask

  task rd(input [9:0] a, input [7:0] m, input [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      chk(q & m, e);
    end
  endtask

  task mode(input [2:0] m);
    @(posedge clk_sys_i) op_mode_i <= m;
  endtask

  // One-cycle event pulse; every pulse input is low again afterwards.
  task pulse(input [2:0] k);
    begin
      @(posedge clk_sys_i);
      case (k)
        0: timeout_event_i <= 1'b1;
        1: preamble_event_i <= 1'b1;
        2: sync_event_i <= 1'b1;
        3: recal_done_i <= 1'b1;
        4: temp_sample_valid_i <= 1'b1;
        5: pa_ramp_done_i <= 1'b1;
        6: rx_settled_i <= 1'b1;
        default: rssi_sampling_start_i <= 1'b1;
      endcase
      @(posedge clk_sys_i);
      {timeout_event_i, preamble_event_i, sync_event_i, recal_done_i} <= 4'h0;
      {temp_sample_valid_i, pa_ramp_done_i, rx_settled_i, rssi_sampling_start_i} <= 4'h0;
    end
  endtask

  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // ====================
  // Scenarios.
  task t_regs;
    begin
      rd(10'h0EC, 8'hFF, 8'h02);
      rd(10'h0F4, 8'hFF, 8'h02);
      bus(1'b1, 10'h0F4, 8'hFF);
      rd(10'h0F4, 8'hFF, 8'h0F);
      chk({4'h0, supply_detector_enable_o, supply_threshold_select_o}, 8'h0F);
      bus(1'b1, 10'h0FC, 8'hFF);
      rd(10'h0FC, 8'hFF, 8'h00);
      mode(`MODE_RX);
      bus(1'b1, 10'h0EC, 8'h85);
      rd(10'h0EC, 8'hFF, 8'h85);
      chk({6'h0, auto_recal_enable_o, thermal_monitor_active_o}, 8'h02);
      bus(1'b1, 10'h0EC, 8'h02);
      chk({6'h0, auto_recal_enable_o, thermal_monitor_active_o}, 8'h01);
    end
  endtask

  // Trigger in standby starts; outside standby it is dropped.
  task t_cal;
    begin
      mode(`MODE_STANDBY);
      bus(1'b1, 10'h0EC, 8'h42);
      chk({7'h0, recal_start_o}, 8'h01);
      rd(10'h0EC, 8'hFF, 8'h22);
      pulse(3'd3);
      rd(10'h0EC, 8'hFF, 8'h02);
      mode(`MODE_RX);
      bus(1'b1, 10'h0EC, 8'h42);
      rd(10'h0EC, 8'hFF, 8'h02);
    end
  endtask

  // A drift of 11 degrees crosses the 5 and 10 steps only; a calibration clears it.
  task t_temp;
    begin
      @(posedge clk_sys_i) temp_sample_i <= 8'h0B;
      pulse(3'd4);
      rd(10'h0F0, 8'hFF, 8'h0B);
      for (i = 0; i < 4; i = i + 1) begin
        bus(1'b1, 10'h0EC, {5'h0, i[1:0], 1'b0});
        rd(10'h0EC, 8'hFF, {4'h0, 11 > 5 * (i + 1), i[1:0], 1'b0});
      end
      bus(1'b1, 10'h0EC, 8'h03);
      @(posedge clk_sys_i) temp_sample_i <= 8'h30;
      pulse(3'd4);
      rd(10'h0F0, 8'hFF, 8'h0B);
      bus(1'b1, 10'h0EC, 8'h02);
      mode(`MODE_STANDBY);
      bus(1'b1, 10'h0EC, 8'h42);
      pulse(3'd3);
      rd(10'h0EC, 8'hFF, 8'h02);
      mode(`MODE_RX);
    end
  endtask

  task t_flags;
    begin
      @(posedge clk_sys_i) signal_strength_reading_i <= 8'h41;
      @(posedge clk_sys_i) signal_strength_reading_i <= 8'h00;
      rd(10'h0F8, 8'h08, 8'h08);
      bus(1'b1, 10'h0F8, 8'h08);
      rd(10'h0F8, 8'h08, 8'h00);
      pulse(3'd2);
      bus(1'b1, 10'h0F8, 8'h01);
      rd(10'h0F8, 8'h01, 8'h01);
      @(posedge clk_sys_i) continuous_mode_i <= 1'b1;
      bus(1'b1, 10'h0F8, 8'h01);
      rd(10'h0F8, 8'h01, 8'h00);
      @(posedge clk_sys_i) continuous_mode_i <= 1'b0;
      pulse(3'd1);
      pulse(3'd0);
      pulse(3'd2);
      @(posedge clk_sys_i) fifo_empty_i <= 1'b1;
      rd(10'h0F8, 8'h07, 8'h02);
      @(posedge clk_sys_i) fifo_empty_i <= 1'b0;
      pulse(3'd0);
      pulse(3'd2);
      @(posedge clk_sys_i) signal_strength_reading_i <= 8'hFF;
      @(posedge clk_sys_i) signal_strength_reading_i <= 8'h00;
      mode(`MODE_STANDBY);
      rd(10'h0F8, 8'h0F, 8'h02);
      bus(1'b1, 10'h0F8, 8'h02);
      rd(10'h0F8, 8'h02, 8'h00);
      @(posedge clk_sys_i) pll_locked_i <= 1'b1;
      mode(`MODE_TX);
      pulse(3'd5);
      rd(10'h0F8, 8'hF0, 8'hB0);
      mode(`MODE_SYNTH);
      rd(10'h0F8, 8'h30, 8'h10);
      @(posedge clk_sys_i) pll_locked_i <= 1'b0;
      rd(10'h0F8, 8'h10, 8'h00);
      mode(`MODE_RX);
      pulse(3'd6);
      rd(10'h0F8, 8'hC0, 8'h40);
      pulse(3'd7);
      rd(10'h0F8, 8'hC0, 8'hC0);
      mode(`MODE_SLEEP);
      rd(10'h0F8, 8'hC0, 8'h80);
      chk({7'h0, thermal_monitor_active_o}, 8'h00);
      mode(`MODE_STANDBY);
      rd(10'h0F8, 8'h80, 8'h00);
      @(posedge clk_sys_i) osc_running_i <= 1'b1;
      rd(10'h0F8, 8'h80, 8'h80);
    end
  endtask

  // Preamble event raises the line only while unmasked.
  task t_irq;
    begin
      bus(1'b1, 10'h140, 8'hFF);
      bus(1'b1, 10'h144, 8'h02);
      rd(10'h144, 8'hFF, 8'h02);
      chk({7'h0, irq_o}, 8'h00);
      pulse(3'd1);
      rd(10'h140, 8'h02, 8'h02);
      chk({7'h0, irq_o}, 8'h01);
      bus(1'b1, 10'h140, 8'h02);
      chk({7'h0, irq_o}, 8'h00);
      bus(1'b1, 10'h0F8, 8'h02);
      bus(1'b1, 10'h144, 8'h00);
      pulse(3'd1);
      rd(10'h140, 8'h02, 8'h02);
      chk({7'h0, irq_o}, 8'h00);
    end
  endtask

  // ====================
  // Main sequence: every input set at time zero, reset held six cycles.
  initial begin
    {sys_rst_i, avs_read_i, avs_write_i} = 3'b100;
    {avs_address_i, avs_writedata_i} = 42'h0;
    op_mode_i = `MODE_STANDBY;
    {signal_strength_reading_i, temp_sample_i} = 16'h0;
    {pll_locked_i, pa_ramp_done_i, timeout_event_i, fifo_empty_i} = 4'h0;
    {preamble_event_i, sync_event_i, continuous_mode_i} = 3'h0;
    {temp_sample_valid_i, recal_done_i} = 2'h0;
    {osc_running_i, rx_settled_i, rssi_sampling_start_i} = 3'h0;
    mismatches = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_regs;
    t_cal;
    t_temp;
    t_flags;
    t_irq;
    results;
  end
endmodule
